// ### src/wkt_cfg.svh
/*
 * Constants of the periodic wakeup timer: register offsets, field positions,
 * reset values, period lengths and timing figures.
 * Assumes it is included by the package and by the design files by bare name.
 */
`ifndef WKT_CFG_SVH
`define WKT_CFG_SVH

// Register offsets on the plain register port.
`define WKT_ADDR_W        2
`define WKT_ADDR_CTRL     2'h0
`define WKT_ADDR_IRQ_ST   2'h1
`define WKT_ADDR_IRQ_MASK 2'h2

// Field positions of the status and control register.
`define WKT_BIT_FLAG      7
`define WKT_BIT_ACK       6
`define WKT_BIT_CLKSEL    5
`define WKT_BIT_IRQEN     4
`define WKT_PSEL_HI       2
`define WKT_PSEL_LO       0
`define WKT_BIT_EVT       0

// Reset values.
`define WKT_CTRL_RST      8'h00
`define WKT_MASK_RST      1'h1
`define WKT_PSEL_OFF      3'h0

// Timing figures: system clock period and internal oscillator period in ns.
`define WKT_MCLK_NS       50
`define WKT_OSC_NS        1000000
`define WKT_DIV_W         16
`define WKT_CNT_W         16

// Period lengths in counted timer clock periods, internal 1 kHz source.
`define WKT_OSC_P1        16'h0008
`define WKT_OSC_P2        16'h0020
`define WKT_OSC_P3        16'h0040
`define WKT_OSC_P4        16'h0080
`define WKT_OSC_P5        16'h0100
`define WKT_OSC_P6        16'h0200
`define WKT_OSC_P7        16'h0400

// Period lengths in counted timer clock periods, external clock source.
`define WKT_EXT_P1        16'h0100
`define WKT_EXT_P2        16'h0400
`define WKT_EXT_P3        16'h0800
`define WKT_EXT_P4        16'h1000
`define WKT_EXT_P5        16'h2000
`define WKT_EXT_P6        16'h4000
`define WKT_EXT_P7        16'h8000

`endif

// ### src/wkt_pkg.sv
/*
 * Types and the period lookup of the periodic wakeup timer.
 * Assumes the constants header is on the include path.
 */
`include "wkt_cfg.svh"

package wkt_pkg;

  typedef enum logic {
    wkt_src_osc,
    wkt_src_ext
  } wkt_src_t;

  typedef logic [2:0] wkt_psel_t;
  typedef logic [`WKT_CNT_W-1:0] wkt_cnt_t;

  // Returns the period length for a code and a source; zero means stopped.
  function automatic wkt_cnt_t wkt_period_len(input wkt_psel_t code, input wkt_src_t src);
    wkt_cnt_t len;
    len = '0;
    case (code)
      3'h1: len = (src == wkt_src_ext) ? `WKT_EXT_P1 : `WKT_OSC_P1;
      3'h2: len = (src == wkt_src_ext) ? `WKT_EXT_P2 : `WKT_OSC_P2;
      3'h3: len = (src == wkt_src_ext) ? `WKT_EXT_P3 : `WKT_OSC_P3;
      3'h4: len = (src == wkt_src_ext) ? `WKT_EXT_P4 : `WKT_OSC_P4;
      3'h5: len = (src == wkt_src_ext) ? `WKT_EXT_P5 : `WKT_OSC_P5;
      3'h6: len = (src == wkt_src_ext) ? `WKT_EXT_P6 : `WKT_OSC_P6;
      3'h7: len = (src == wkt_src_ext) ? `WKT_EXT_P7 : `WKT_OSC_P7;
      default: len = '0;
    endcase
    return len;
  endfunction

endpackage

// ### src/wkt_tick_gen.sv
/*
 * Timer clock source: a divider standing in for the internal 1 kHz oscillator
 * and a rising edge detector on the external clock, one of them selected.
 * Assumes the external clock input is synchronous to mclk_i and slower than half of it.
 */
`timescale 1ns/1ns
`include "wkt_cfg.svh"

module wkt_tick_gen
  import wkt_pkg::*;
#(
  parameter int unsigned OSC_DIV = `WKT_OSC_NS / `WKT_MCLK_NS
) (
  input  logic     mclk_i,
  input  logic     reset_i,
  input  wkt_src_t clk_sel_i,
  input  logic     ext_clk_i,
  output logic     tick_o
);

  logic [`WKT_DIV_W-1:0] div;
  logic [`WKT_DIV_W-1:0] next_div;
  logic                  ext_prev;
  wire                   div_last;
  wire                   osc_tick;
  wire                   ext_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Divider and edge detection.

  assign div_last = (div == `WKT_DIV_W'(OSC_DIV - 1));
  assign next_div = div_last ? '0 : div + `WKT_DIV_W'(1);
  assign osc_tick = div_last;
  assign ext_rise = ext_clk_i & ~ext_prev;
  assign tick_o   = (clk_sel_i == wkt_src_ext) ? ext_rise : osc_tick;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      div      <= '0;
      ext_prev <= 1'b0;
    end else begin
      div      <= next_div;
      ext_prev <= ext_clk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_osc_tick_spacing: assert property (@(posedge mclk_i) disable iff (reset_i)
    (clk_sel_i == wkt_src_osc && tick_o) |=> !osc_tick)
    else $error("Oscillator ticks came back to back.");

endmodule

// ### src/wkt_period_cnt.sv
/*
 * Wakeup period counter: counts timer ticks up to the selected period length,
 * pulses at the end of each period and restarts; code zero holds it cleared.
 * Assumes tick_i is a one-cycle pulse on mclk_i.
 */
`timescale 1ns/1ns
`include "wkt_cfg.svh"

module wkt_period_cnt
  import wkt_pkg::*;
(
  input  logic      mclk_i,
  input  logic      reset_i,
  input  logic      tick_i,
  input  wkt_psel_t period_sel_i,
  input  wkt_src_t  clk_sel_i,
  output logic      timeout_o,
  output wkt_cnt_t  count_o
);

  wkt_cnt_t            count;
  wkt_cnt_t            next_count;
  wkt_cnt_t            period;
  wire [`WKT_CNT_W:0]  count_inc;
  wire                 running;
  wire                 at_end;

  ////////////////////////////////////////////////////////////////////////////
  // Period decode and count.

  assign period    = wkt_period_len(period_sel_i, clk_sel_i);
  assign running   = (period_sel_i != `WKT_PSEL_OFF);
  assign count_inc = {1'b0, count} + (`WKT_CNT_W+1)'(1);
  assign at_end    = tick_i && (count_inc >= {1'b0, period});
  assign timeout_o = running && at_end;
  assign next_count = !running ? '0 :
                      at_end  ? '0 :
                      tick_i  ? count_inc[`WKT_CNT_W-1:0] : count;
  assign count_o   = count;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_stop_holds_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (period_sel_i == `WKT_PSEL_OFF) |=> (count == '0))
    else $error("Counter not held cleared with the stop code.");

  a_timeout_at_period: assert property (@(posedge mclk_i) disable iff (reset_i)
    timeout_o |-> (tick_i && count_inc >= {1'b0, wkt_period_len(period_sel_i, clk_sel_i)}))
    else $error("Timeout raised before the period elapsed.");

  a_restart_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    timeout_o |=> (count == '0))
    else $error("Counter did not restart after a timeout.");

endmodule

// ### src/wkt_timer.sv
/*
 * Periodic wakeup timer top: register port, timeout flag, interrupt status
 * and mask, and the interrupt output; instantiates tick source and counter.
 * Assumes a plain register port master: one-cycle strobes, read data the next cycle.
 */
`timescale 1ns/1ns
`include "wkt_cfg.svh"

module wkt_timer
  import wkt_pkg::*;
#(
  parameter int unsigned OSC_DIV = `WKT_OSC_NS / `WKT_MCLK_NS
) (
  input  logic                   mclk_i,
  input  logic                   reset_i,
  input  logic [`WKT_ADDR_W-1:0] addr_i,
  input  logic [7:0]             wr_data_i,
  input  logic                   wr_strobe_i,
  input  logic                   rd_strobe_i,
  input  logic                   ext_clk_i,
  output logic [7:0]             rd_data_o,
  output logic                   irq_o,
  output logic                   timeout_flag_o
);

  logic       flag;
  logic       irq_en;
  logic       irq_mask;
  wkt_src_t   clk_sel;
  wkt_psel_t  period_sel;
  logic       tick;
  logic       timeout;
  wkt_cnt_t   count;
  logic       next_flag;
  logic       next_irq_en;
  logic       next_irq_mask;
  wkt_src_t   next_clk_sel;
  wkt_psel_t  next_period_sel;
  wire        sel_ctrl;
  wire        sel_irq_st;
  wire        sel_irq_mask;
  wire        wr_ctrl;
  wire        wr_mask;
  wire        flag_ack;
  wire        flag_w1c;
  wire  [7:0] ctrl_view;
  wire  [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Tick source and period counter.

  wkt_tick_gen #(
    .OSC_DIV (OSC_DIV)
  ) u_tick (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .clk_sel_i (clk_sel),
    .ext_clk_i (ext_clk_i),
    .tick_o    (tick)
  );

  wkt_period_cnt u_cnt (
    .mclk_i       (mclk_i),
    .reset_i      (reset_i),
    .tick_i       (tick),
    .period_sel_i (period_sel),
    .clk_sel_i    (clk_sel),
    .timeout_o    (timeout),
    .count_o      (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and write effects.

  assign sel_ctrl     = (addr_i == `WKT_ADDR_CTRL);
  assign sel_irq_st   = (addr_i == `WKT_ADDR_IRQ_ST);
  assign sel_irq_mask = (addr_i == `WKT_ADDR_IRQ_MASK);
  assign wr_ctrl      = wr_strobe_i & sel_ctrl;
  assign wr_mask      = wr_strobe_i & sel_irq_mask;
  assign flag_ack     = wr_ctrl & wr_data_i[`WKT_BIT_ACK];
  assign flag_w1c     = wr_strobe_i & sel_irq_st & wr_data_i[`WKT_BIT_EVT];

  // A timeout in the same cycle as an acknowledge keeps the flag set.
  assign next_flag       = timeout | (flag & ~(flag_ack | flag_w1c));
  assign next_clk_sel    = wr_ctrl ? wkt_src_t'(wr_data_i[`WKT_BIT_CLKSEL]) : clk_sel;
  assign next_irq_en     = wr_ctrl ? wr_data_i[`WKT_BIT_IRQEN] : irq_en;
  assign next_period_sel = wr_ctrl ? wr_data_i[`WKT_PSEL_HI:`WKT_PSEL_LO] : period_sel;
  assign next_irq_mask   = wr_mask ? wr_data_i[`WKT_BIT_EVT] : irq_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Read view.

  assign ctrl_view = {flag, 1'b0, clk_sel, irq_en, 1'b0, period_sel};
  assign rd_mux    = sel_ctrl     ? ctrl_view :
                     sel_irq_st   ? {7'h00, flag} :
                     sel_irq_mask ? {7'h00, irq_mask} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flag           <= 1'b0;
      clk_sel        <= wkt_src_osc;
      irq_en         <= 1'b0;
      period_sel     <= `WKT_PSEL_OFF;
      irq_mask       <= `WKT_MASK_RST;
      rd_data_o      <= `WKT_CTRL_RST;
      irq_o          <= 1'b0;
      timeout_flag_o <= 1'b0;
    end else begin
      flag           <= next_flag;
      clk_sel        <= next_clk_sel;
      irq_en         <= next_irq_en;
      period_sel     <= next_period_sel;
      irq_mask       <= next_irq_mask;
      rd_data_o      <= rd_strobe_i ? rd_mux : 8'h00;
      irq_o          <= next_flag & next_irq_en & next_irq_mask;
      timeout_flag_o <= next_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk_i);
  endclocking

  default disable iff (reset_i);

  a_flag_reads_back: assert property (
    (rd_strobe_i && sel_ctrl) |=> (rd_data_o[7] == $past(flag)))
    else $error("Read of the flag bit does not match the flag.");

  a_timeout_sets_flag: assert property (
    timeout |=> (flag && timeout_flag_o))
    else $error("Timeout did not set the flag.");

  a_ack_clears_flag: assert property (
    (flag_ack && !timeout) |=> (!flag && !irq_o))
    else $error("Acknowledge did not clear the flag.");

  a_ack_zero_keeps: assert property (
    (flag && wr_ctrl && !wr_data_i[`WKT_BIT_ACK]) |=> flag)
    else $error("Writing zero to the acknowledge bit changed the flag.");

  a_ack_reads_zero: assert property (
    rd_strobe_i |=> (rd_data_o[6] == 1'b0))
    else $error("Acknowledge bit did not read as zero.");

  a_clksel_store: assert property (
    wr_ctrl |=> (clk_sel == $past(wr_data_i[5])) && (period_sel == $past(wr_data_i[2:0])))
    else $error("Clock select or period code not stored.");

  a_irq_gated: assert property (
    !irq_en |-> !irq_o)
    else $error("Interrupt raised while disabled.");

  a_irq_follows: assert property (
    irq_o == (flag && irq_en && irq_mask))
    else $error("Interrupt output does not follow flag and enable.");

  a_stop_no_timeout: assert property (
    (period_sel == `WKT_PSEL_OFF) [*2] |-> !timeout && (count == '0))
    else $error("Counter ran with the stop code.");

  a_w1c_clears_flag: assert property (
    (flag_w1c && !timeout) |=> (!flag && !irq_o))
    else $error("Status write of one did not clear the flag.");

  a_set_wins_clear: assert property (
    (timeout && (flag_ack || flag_w1c)) |=> flag)
    else $error("Clear in the timeout cycle dropped the flag.");

  a_flag_no_spurious: assert property (
    (!flag && !timeout) |=> !flag)
    else $error("Flag set without a timeout.");

  a_flag_holds: assert property (
    (flag && !flag_ack && !flag_w1c) |=> flag)
    else $error("Flag dropped without a clear.");

  a_flag_out_copy: assert property (
    timeout_flag_o == flag)
    else $error("Flag output differs from the flag.");

  a_irqen_store: assert property (
    wr_ctrl |=> (irq_en == $past(wr_data_i[`WKT_BIT_IRQEN])))
    else $error("Interrupt enable not stored.");

  a_ctrl_no_write: assert property (
    !wr_ctrl |=> (period_sel == $past(period_sel)) &&
                 (clk_sel == $past(clk_sel)) &&
                 (irq_en == $past(irq_en)))
    else $error("Control field changed without a write.");

  a_mask_store: assert property (
    wr_mask |=> (irq_mask == $past(wr_data_i[`WKT_BIT_EVT])))
    else $error("Interrupt mask not stored.");

  a_rd_ctrl_fields: assert property (
    (rd_strobe_i && sel_ctrl) |=>
      (rd_data_o[5:0] == {$past(clk_sel), $past(irq_en), 1'b0, $past(period_sel)}))
    else $error("Control read does not show the stored fields.");

  a_rd_idle_zero: assert property (
    !rd_strobe_i |=> (rd_data_o == 8'h00))
    else $error("Read data not zero outside a read.");

  a_rd_status_view: assert property (
    (rd_strobe_i && sel_irq_st) |=> (rd_data_o == {7'h00, $past(flag)}))
    else $error("Status read does not show the flag.");

  a_rd_unmapped: assert property (
    (rd_strobe_i && !sel_ctrl && !sel_irq_st && !sel_irq_mask) |=> (rd_data_o == 8'h00))
    else $error("Unmapped address did not read zero.");

  a_count_hold: assert property (
    (!tick && (period_sel != `WKT_PSEL_OFF)) |=> (count == $past(count)))
    else $error("Counter moved without a tick.");

  a_count_step: assert property (
    (tick && (period_sel != `WKT_PSEL_OFF) && !timeout) |=> (count == wkt_cnt_t'($past(count) + 16'h0001)))
    else $error("Counter did not step on a tick.");

endmodule

// ### bench/wkt_timer_bench.sv
/*
 * Self-checking bench of the periodic wakeup timer: register map, flag, interrupt and period lengths.
 * Assumes the package, the constants header and the design files are compiled first.
 */
`timescale 1ns/1ns

module wkt_timer_bench;
  localparam int DIV      = 4;
  localparam int LIMIT    = 80000;
  localparam int WAIT_MAX = 10000;

  logic       mclk_i;
  logic       reset_i;
  logic [1:0] addr_i;
  logic [7:0] wr_data_i;
  logic       wr_strobe_i;
  logic       rd_strobe_i;
  logic       ext_clk_i;
  logic [7:0] rd_data_o;
  logic       irq_o;
  logic       timeout_flag_o;
  logic       ext_run;
  logic [7:0] r;
  logic [7:0] d;
  int         error_cnt;
  int         check_count;
  int         cyc = 0;
  int         t0;
  int         seed;

  wkt_timer #(.OSC_DIV(DIV)) dut (
    .mclk_i        (mclk_i),
    .reset_i       (reset_i),
    .addr_i        (addr_i),
    .wr_data_i     (wr_data_i),
    .wr_strobe_i   (wr_strobe_i),
    .rd_strobe_i   (rd_strobe_i),
    .ext_clk_i     (ext_clk_i),
    .rd_data_o     (rd_data_o),
    .irq_o         (irq_o),
    .timeout_flag_o(timeout_flag_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // External clock toggles each cycle while running, so one rising edge every two cycles.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    ext_clk_i <= ext_run ? ~ext_clk_i : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_strobe_i <= 1'b1;
    @(posedge mclk_i);
    wr_strobe_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_strobe_i <= 1'b1;
    @(posedge mclk_i);
    rd_strobe_i <= 1'b0;
    #1 r = rd_data_o;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (timeout_flag_o !== 1'b1 && n < WAIT_MAX) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("flag_wait", n < WAIT_MAX, 1);
  endtask

  // Model: period in ticks from the code, ticks turned into system clock cycles.
  task automatic run(input logic sel, input logic [2:0] code, input logic en);
    int len;
    int t;
    len = (code == 3'h1) ? 256 : 256 << code;
    len = sel ? len * 2 : len / 32 * DIV;
    ext_run = sel;
    wr(2'h0, {2'b01, sel, en, 1'b0, code});
    wait_flag();
    t = cyc;
    chk("irq", irq_o, en);
    rd(2'h0);
    chk("ctrl", r, {2'b10, sel, en, 1'b0, code});
    wr(2'h0, {2'b00, sel, en, 1'b0, code});
    chk("keep", timeout_flag_o, 1);
    if (code == 3'h3) begin
      wr(2'h2, 8'h00);
      chk("masked", irq_o, 0);
      rd(2'h1);
      chk("status", r, 1);
      wr(2'h1, 8'h01);
      wr(2'h2, 8'h01);
    end else begin
      wr(2'h0, {2'b01, sel, en, 1'b0, code});
    end
    chk("clear", timeout_flag_o, 0);
    chk("irq_low", irq_o, 0);
    wait_flag();
    chk("period", cyc - t, len);
    $display("period test source %0d code %0d done", sel, code);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 71;
    error_cnt = 0;
    check_count = 0;
    reset_i = 1'b1;
    addr_i = 2'h0;
    wr_data_i = 8'h00;
    wr_strobe_i = 1'b0;
    rd_strobe_i = 1'b0;
    ext_run = 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    fork
      begin
        for (int a = 0; a < 4; a++) begin
          rd(a[1:0]);
          chk("reset_value", r, a == 2);
        end
        chk("reset_irq", irq_o, 0);
        $display("reset test done");
        repeat (6) begin
          d = $random(seed);
          wr(2'h0, d);
          rd(2'h0);
          chk("ctrl_rw", r, d & 8'h37);
          wr(2'h0, 8'h00);
          wr(2'h3, d);
          rd(2'h3);
          chk("unmapped", r, 0);
        end
        $display("register test done");
        for (int c = 1; c < 8; c++)
          run(1'b0, c[2:0], c[0]);
        run(1'b1, 3'h1, 1'b1);
        run(1'b1, 3'h2, 1'b0);
        run(1'b1, 3'h3, 1'b1);
        run(1'b1, 3'h4, 1'b0);
        for (int s = 0; s < 2; s++) begin
          ext_run = s[0];
          wr(2'h0, {2'b01, s[0], 5'h10});
          repeat (600) @(posedge mclk_i);
          #1;
          chk("stopped", timeout_flag_o, 0);
          chk("stopped_irq", irq_o, 0);
        end
        // After the stop code the count starts from zero: a full period of external ticks.
        wr(2'h0, {2'b01, 1'b1, 5'h11});
        t0 = cyc;
        wait_flag();
        chk("restart", (cyc - t0) inside {[2*256-1:2*256]}, 1);
        $display("stop test done");
      end
      begin
        wait (cyc >= LIMIT);
        chk("timeout", 32'h1, 32'h0);
      end
    join_any
    final_report();
  end
endmodule
